/* deframer_check_pkg.sv */
// shared constants and types for the deframer link-test logic
package deframer_check_pkg;

  // ---------------------------------------------------------------
  // pattern checking
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PATTERN_OFF = 2'b00,
    PATTERN_7   = 2'b01,
    PATTERN_15  = 2'b10,
    PATTERN_31  = 2'b11
  } pattern_order_t;

  typedef enum logic {
    CHECK_AT_LANE   = 1'b0,
    CHECK_AT_SAMPLE = 1'b1
  } check_point_t;

  localparam int unsigned NUM_LANES    = 4;
  localparam int unsigned TALLY_W      = 8;
  localparam logic [7:0]  TALLY_RST    = 8'h00;
  localparam logic [7:0]  TALLY_MAX    = 8'hFF;
  localparam int unsigned HIST_W       = 31;
  localparam logic [5:0]  SEED_BITS    = 6'h1F;
  localparam int unsigned SAMPLE_SLOT  = 4;

  // ---------------------------------------------------------------
  // ilas comparison
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] did;
    logic [3:0] bid;
    logic [4:0] lid0;
    logic [4:0] l;
    logic       scr;
    logic [7:0] f;
    logic [4:0] k;
    logic [7:0] m;
    logic [4:0] n;
    logic [1:0] cs;
    logic [4:0] np;
    logic [4:0] s;
    logic [4:0] cf;
    logic       hd;
  } lane_params_t;

  localparam int unsigned MM_DID       = 0;
  localparam int unsigned MM_BID       = 1;
  localparam int unsigned MM_LID0      = 2;
  localparam int unsigned MM_L         = 3;
  localparam int unsigned MM_SCR       = 4;
  localparam int unsigned MM_F         = 5;
  localparam int unsigned MM_K         = 6;
  localparam int unsigned MM_M         = 7;
  localparam int unsigned MM_N         = 8;
  localparam int unsigned MM_CS        = 9;
  localparam int unsigned MM_NP        = 10;
  localparam int unsigned MM_S         = 11;
  localparam int unsigned MM_CF        = 12;
  localparam int unsigned MM_HD        = 13;
  localparam int unsigned MM_CSUM_BASE = 14;
  localparam logic [31:0] MISMATCH_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // converter routing
  // ---------------------------------------------------------------
  localparam int unsigned NUM_DAC      = 4;
  localparam logic [1:0]  ROUTE_RST_0  = 2'h0;
  localparam logic [2:0]  CONV_EN_RST  = 3'h4;

endpackage : deframer_check_pkg

/* pattern_check_if.sv */
// carries control and results between the top and one pattern checker
`timescale 1ns/10ps
interface pattern_check_if #(parameter int unsigned DATA_W = 8);
  import deframer_check_pkg::*;
  pattern_order_t     order;
  logic               clear;
  logic [DATA_W-1:0]  word;
  logic               valid;
  logic [TALLY_W-1:0] tally;
  logic               inverted;

  modport sink    (input order, input clear, input word, input valid,
                   output tally, output inverted);
  modport owner   (output order, output clear, output word, output valid,
                   input tally, input inverted);
endinterface : pattern_check_if

/* pattern_checker.sv */
// self-synchronising pattern checker with saturating error tally
`timescale 1ns/10ps
module pattern_checker
  import deframer_check_pkg::*;
#(
  parameter int unsigned DATA_W = 8
)(
  input  wire logic       clk_sys_i,  // system clock
  input  wire logic       rst_b_i,    // synchronous reset, active low
  pattern_check_if.sink    chk        // control and results
);

  logic [HIST_W-1:0] hist_q, hist_d;
  logic [DATA_W-1:0] diff;
  logic [5:0]        seen_q;
  pattern_order_t    order_q;
  logic              synced;
  logic              hit;

  // ---------------------------------------------------------------
  // prediction from the received history
  // ---------------------------------------------------------------
  always_comb
  begin
    hist_d = hist_q;
    diff   = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      unique case (chk.order)
        PATTERN_7:  diff[i] = chk.word[i] ^ hist_d[6] ^ hist_d[5];
        PATTERN_15: diff[i] = chk.word[i] ^ hist_d[14] ^ hist_d[13];
        PATTERN_31: diff[i] = chk.word[i] ^ hist_d[30] ^ hist_d[27];
        default:    diff[i] = 1'b0;
      endcase
      hist_d = {hist_d[HIST_W-2:0], chk.word[i]};
    end
  end

  assign synced = (seen_q >= SEED_BITS);
  // a fully inverted word is a valid inverted sequence, not an error
  assign hit    = chk.valid && synced && (diff != '0) && (diff != '1);

  // ---------------------------------------------------------------
  // seeding
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || chk.order == PATTERN_OFF || chk.order != order_q)
    begin
      hist_q <= '0;
      seen_q <= '0;
    end
    else if (chk.valid)
    begin
      hist_q <= hist_d;
      if (!synced)
        seen_q <= (seen_q + 6'(DATA_W) > SEED_BITS) ? SEED_BITS : seen_q + 6'(DATA_W);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      order_q <= PATTERN_OFF;
    else
      order_q <= chk.order;
  end

  // ---------------------------------------------------------------
  // tally and inversion flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || chk.clear)
      chk.tally <= TALLY_RST;
    else if (hit && chk.tally != TALLY_MAX)
      chk.tally <= chk.tally + 8'h01;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || chk.order == PATTERN_OFF)
      chk.inverted <= 1'b0;
    else if (chk.valid && synced)
      chk.inverted <= (diff == '1);
  end

  property p_tally_sat;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (chk.tally == TALLY_MAX && !chk.clear) |=> (chk.tally == TALLY_MAX);
  endproperty
  a_tally_sat: assert property (p_tally_sat) else $error("tally wrapped");

  property p_clear;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    chk.clear |=> (chk.tally == TALLY_RST);
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed");

  property p_no_count_unsynced;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (!synced && !chk.clear) |=> (chk.tally == $past(chk.tally));
  endproperty
  a_no_count_unsynced: assert property (p_no_count_unsynced) else $error("count before seed");

  property p_step_one;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (!chk.clear && chk.tally != TALLY_MAX && hit) |=> (chk.tally == $past(chk.tally) + 8'h01);
  endproperty
  a_step_one: assert property (p_step_one) else $error("tally step wrong");

endmodule : pattern_checker

/* deframer_prbs_ilas_check.sv */
// link-test, ilas check and converter routing for the deframer side
`timescale 1ns/10ps
// Summary of operation
// - pattern off, order 7, 15 or 31
// - lane mode checks raw deserializer output
// - four independent lane checkers
// - sample mode checks deframer output 0 only
// - clear zeroes all tallies together
// - each checker keeps 8-bit error tally
// - lane selector 0 to 3 picks one tally
// - sample mode ignores lane selector
// - four-bit inverted-sequence mask per lane
// - first silicon returns lane 0 tally
// - lane 0 ilas compared, 32-bit mask
// - bits 0-13 flag DID through HD
// - bits 14-17 flag lane checksum mismatches
// - received and local parameters read back
// - crossbar routes any output to any converter
// - fewer converters use lowest deframer outputs
// - status flags valid lane 0 checksum
module deframer_prbs_ilas_check
  import deframer_check_pkg::*;
#(
  parameter int unsigned LANE_W        = 8,
  parameter int unsigned SAMPLE_W      = 16,
  parameter bit          FIRST_SILICON = 1'b0
)(
  input  wire logic                    clk_sys_i,                 // system clock
  input  wire logic                    rst_b_i,                   // sync reset, low
  input  wire logic [1:0]              pattern_order_select_i,    // pattern order
  input  wire logic                    check_point_select_i,      // lane or sample
  input  wire logic                    tally_clear_i,             // clear all tallies
  input  wire logic [1:0]              lane_select_i,             // tally readback lane
  input  wire logic [NUM_LANES*LANE_W-1:0] lane_data_i,           // deserializer words
  input  wire logic [NUM_LANES-1:0]    lane_valid_i,              // lane word strobes
  input  wire logic [NUM_DAC*SAMPLE_W-1:0] deframer_out_i,        // deframer outputs
  input  wire logic                    sample_valid_i,            // sample strobe
  input  wire lane_params_t            local_link_config_i,       // own configuration
  input  wire lane_params_t            ilas_params_i,             // lane 0 ilas fields
  input  wire logic                    ilas_valid_i,              // ilas capture pulse
  input  wire logic [NUM_LANES*5-1:0]  ilas_lid_i,                // lane ids per lane
  input  wire logic [NUM_LANES*8-1:0]  ilas_checksum_i,           // checksums per lane
  input  wire logic                    route_load_i,              // load route pair
  input  wire logic                    tx_channel_select_i,       // 0 tx1, 1 tx2
  input  wire logic [1:0]              route_i_src_i,             // source for I
  input  wire logic [1:0]              route_q_src_i,             // source for Q
  input  wire logic [2:0]              converters_enabled_i,      // active outputs 1..4
  output logic [TALLY_W-1:0]           pattern_error_tally_o,     // selected tally
  output logic [NUM_LANES-1:0]         pattern_inverted_mask_o,   // inverted lanes
  output logic [31:0]                  ilas_mismatch_o,           // mismatch mask
  output logic                         checksum_valid_o,          // lane 0 checksum ok
  output lane_params_t                 received_lane0_params_o,   // captured ilas
  output lane_params_t                 local_link_config_o,       // own config copy
  output logic [NUM_DAC*2-1:0]         converter_route_map_o,     // route selects
  output logic [NUM_DAC*SAMPLE_W-1:0]  dac_sample_o               // tx1 I,Q, tx2 I,Q
);

  // ---------------------------------------------------------------
  // checker control
  // ---------------------------------------------------------------
  pattern_order_t order_sel;
  check_point_t   point_sel;
  logic [TALLY_W-1:0] tally   [NUM_LANES+1];
  logic               inv     [NUM_LANES+1];

  assign order_sel = pattern_order_t'(pattern_order_select_i);
  assign point_sel = check_point_t'(check_point_select_i);

  genvar g;
  generate
    for (g = 0; g < NUM_LANES; g++)
    begin : g_lane
      pattern_check_if #(.DATA_W(LANE_W)) lane_if ();
      // lane checkers only run at the lane point, on raw lane words
      assign lane_if.order = (point_sel == CHECK_AT_LANE) ? order_sel : PATTERN_OFF;
      assign lane_if.clear = tally_clear_i;
      assign lane_if.word  = lane_data_i[g*LANE_W +: LANE_W];
      assign lane_if.valid = lane_valid_i[g];
      assign tally[g]      = lane_if.tally;
      assign inv[g]        = lane_if.inverted;
      pattern_checker #(.DATA_W(LANE_W)) u_lane_chk (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .chk       (lane_if)
      );
    end
  endgenerate

  pattern_check_if #(.DATA_W(SAMPLE_W)) smp_if ();
  assign smp_if.order = (point_sel == CHECK_AT_SAMPLE) ? order_sel : PATTERN_OFF;
  assign smp_if.clear = tally_clear_i;
  assign smp_if.word  = deframer_out_i[SAMPLE_W-1:0];
  assign smp_if.valid = sample_valid_i;
  assign tally[SAMPLE_SLOT] = smp_if.tally;
  assign inv[SAMPLE_SLOT]   = smp_if.inverted;

  pattern_checker #(.DATA_W(SAMPLE_W)) u_smp_chk (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .chk       (smp_if)
  );

  // ---------------------------------------------------------------
  // tally readback
  // ---------------------------------------------------------------
  logic [TALLY_W-1:0]   tally_d;
  logic [NUM_LANES-1:0] inv_d;

  always_comb
  begin
    if (point_sel == CHECK_AT_SAMPLE)
      tally_d = tally[SAMPLE_SLOT];
    else if (FIRST_SILICON)
      tally_d = tally[0];
    else
      tally_d = tally[lane_select_i];
    for (int i = 0; i < NUM_LANES; i++)
      inv_d[i] = inv[i];
    if (point_sel == CHECK_AT_SAMPLE)
      inv_d = {{(NUM_LANES-1){1'b0}}, inv[SAMPLE_SLOT]};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      pattern_error_tally_o <= TALLY_RST;
    else
      pattern_error_tally_o <= tally_d;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      pattern_inverted_mask_o <= '0;
    else
      pattern_inverted_mask_o <= inv_d;
  end

  // ---------------------------------------------------------------
  // ilas comparison
  // ---------------------------------------------------------------
  function automatic logic [7:0] param_sum(input lane_params_t p, input logic [4:0] lid);
    logic [7:0] s;
    s = p.did + 8'(p.bid) + 8'(lid) + 8'(p.l) + 8'(p.scr) + p.f + 8'(p.k) + p.m
        + 8'(p.n) + 8'(p.cs) + 8'(p.np) + 8'(p.s) + 8'(p.cf) + 8'(p.hd);
    return s;
  endfunction : param_sum

  lane_params_t rx_q;
  logic         rx_seen_q;
  logic [31:0]  mm_d;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      rx_q <= '0;
    else if (ilas_valid_i)
      rx_q <= ilas_params_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      rx_seen_q <= 1'b0;
    else if (ilas_valid_i)
      rx_seen_q <= 1'b1;
  end

  always_comb
  begin
    mm_d          = MISMATCH_RST;
    mm_d[MM_DID]  = rx_q.did  != local_link_config_i.did;
    mm_d[MM_BID]  = rx_q.bid  != local_link_config_i.bid;
    mm_d[MM_LID0] = rx_q.lid0 != local_link_config_i.lid0;
    mm_d[MM_L]    = rx_q.l    != local_link_config_i.l;
    mm_d[MM_SCR]  = rx_q.scr  != local_link_config_i.scr;
    mm_d[MM_F]    = rx_q.f    != local_link_config_i.f;
    mm_d[MM_K]    = rx_q.k    != local_link_config_i.k;
    mm_d[MM_M]    = rx_q.m    != local_link_config_i.m;
    mm_d[MM_N]    = rx_q.n    != local_link_config_i.n;
    mm_d[MM_CS]   = rx_q.cs   != local_link_config_i.cs;
    mm_d[MM_NP]   = rx_q.np   != local_link_config_i.np;
    mm_d[MM_S]    = rx_q.s    != local_link_config_i.s;
    mm_d[MM_CF]   = rx_q.cf   != local_link_config_i.cf;
    mm_d[MM_HD]   = rx_q.hd   != local_link_config_i.hd;
    for (int i = 0; i < NUM_LANES; i++)
      mm_d[MM_CSUM_BASE+i] = param_sum(rx_q, ilas_lid_i[i*5 +: 5])
                             != ilas_checksum_i[i*8 +: 8];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      ilas_mismatch_o <= MISMATCH_RST;
    else
      ilas_mismatch_o <= mm_d;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      checksum_valid_o <= 1'b0;
    else
      checksum_valid_o <= rx_seen_q && !mm_d[MM_CSUM_BASE];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      received_lane0_params_o <= '0;
      local_link_config_o     <= '0;
    end
    else
    begin
      received_lane0_params_o <= rx_q;
      local_link_config_o     <= local_link_config_i;
    end
  end

  // ---------------------------------------------------------------
  // converter crossbar
  // ---------------------------------------------------------------
  logic [1:0] route_q [NUM_DAC];

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < NUM_DAC; i++)
        route_q[i] <= 2'(i);
    end
    else if (route_load_i)
    begin
      route_q[{tx_channel_select_i, 1'b0}] <= route_i_src_i;
      route_q[{tx_channel_select_i, 1'b1}] <= route_q_src_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      converter_route_map_o <= '0;
    else
      for (int i = 0; i < NUM_DAC; i++)
        converter_route_map_o[i*2 +: 2] <= route_q[i];
  end

  logic [1:0] src_eff [NUM_DAC];

  always_comb
  begin
    for (int i = 0; i < NUM_DAC; i++)
      // a source beyond the enabled count falls back to output 0
      src_eff[i] = ({1'b0, route_q[i]} < converters_enabled_i) ? route_q[i] : ROUTE_RST_0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      dac_sample_o <= '0;
    else
      for (int i = 0; i < NUM_DAC; i++)
        dac_sample_o[i*SAMPLE_W +: SAMPLE_W] <= deframer_out_i[src_eff[i]*SAMPLE_W +: SAMPLE_W];
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_sample_ignores_lane;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (point_sel == CHECK_AT_SAMPLE) |=> (pattern_error_tally_o == $past(tally[SAMPLE_SLOT]));
  endproperty
  a_sample_ignores_lane: assert property (p_sample_ignores_lane) else $error("sample tally");

  property p_lane_pick;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (point_sel == CHECK_AT_LANE && !FIRST_SILICON)
      |=> (pattern_error_tally_o == $past(tally[lane_select_i]));
  endproperty
  a_lane_pick: assert property (p_lane_pick) else $error("lane tally");

  property p_upper_zero;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    ilas_mismatch_o[31:18] == 14'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("mask high bits set");

  property p_did_flag;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (rx_q.did != local_link_config_i.did) |=> ilas_mismatch_o[MM_DID];
  endproperty
  a_did_flag: assert property (p_did_flag) else $error("did mismatch lost");

  property p_csum_tie;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    checksum_valid_o |-> !ilas_mismatch_o[MM_CSUM_BASE];
  endproperty
  a_csum_tie: assert property (p_csum_tie) else $error("checksum flags disagree");

  property p_route_load;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (route_load_i && !tx_channel_select_i) |=> ##1 (converter_route_map_o[1:0] == $past(route_i_src_i, 2));
  endproperty
  a_route_load: assert property (p_route_load) else $error("route not loaded");

endmodule : deframer_prbs_ilas_check

/* bb_pattern_model.sv */
// pattern source model of the baseband host transmitter lanes
`timescale 1ns/10ps
module bb_pattern_model
(
  input  wire logic        clk_sys_i,    // system clock
  input  wire logic [1:0]  order_i,      // polynomial, 0 = silent
  input  wire logic        run_i,        // link sending
  input  wire logic [3:0]  err_mask_i,   // flip bit 3 on these lanes
  input  wire logic [3:0]  inv_mask_i,   // send these lanes inverted
  output logic      [31:0] lane_data_o,  // lane words, bit0 first
  output logic      [3:0]  lane_valid_o  // lane strobes
);
  logic [30:0] hist;
  logic [7:0]  w;
  logic        nb;

  initial
  begin
    hist = '1;
    lane_data_o = 32'h0000_0000;
    lane_valid_o = 4'h0;
  end

  // ---------------------------------------------------------------
  // word generation
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (order_i == 2'h0)
    begin
      hist = '1;
    end
    if (run_i && order_i != 2'h0)
    begin
      for (int b = 0; b < 8; b++)
      begin
        case (order_i)
          2'h1:    nb = hist[6] ^ hist[5];
          2'h2:    nb = hist[14] ^ hist[13];
          default: nb = hist[30] ^ hist[27];
        endcase
        w[b] = nb;
        hist = {hist[29:0], nb};
      end
      for (int g = 0; g < 4; g++)
      begin
        lane_data_o[g*8+:8] <= w ^ {4'h0, err_mask_i[g], 3'h0} ^ {8{inv_mask_i[g]}};
      end
      lane_valid_o <= 4'hF;
    end
    else
    begin
      lane_data_o <= ~lane_data_o;
      lane_valid_o <= 4'h0;
    end
  end
endmodule : bb_pattern_model

/* deframer_prbs_ilas_check_tb_top.sv */
// self-checking testbench for the deframer link-test logic
`timescale 1ns/10ps
module deframer_prbs_ilas_check_tb_top
  import deframer_check_pkg::*;
;
  logic         clk_sys, rst_b, clr, smode, ilas_v, r_load, r_tx, csv_o, run;
  logic [1:0]   order_sel, lsel, r_isrc, r_qsrc;
  logic [2:0]   conv_en;
  logic [3:0]   err, inv, lane_v, inv_o;
  logic [7:0]   tally_o, route_o, dfo0, got;
  logic [23:0]  dfo_hi;
  logic [19:0]  ilas_lid;
  logic [31:0]  lane_d, mm_o, dac_o, ilas_cks;
  lane_params_t local_cfg, ilas_p, rx_o, lc_o;
  int           num_errors, total_checks;

  deframer_prbs_ilas_check #(.SAMPLE_W(8)) u_deframer_prbs_ilas_check (
    .clk_sys_i(clk_sys), .rst_b_i(rst_b), .pattern_order_select_i(order_sel),
    .check_point_select_i(smode), .tally_clear_i(clr), .lane_select_i(lsel),
    .lane_data_i(lane_d), .lane_valid_i(lane_v),
    .deframer_out_i({dfo_hi, smode ? lane_d[15:8] : dfo0}), .sample_valid_i(lane_v[1]),
    .local_link_config_i(local_cfg), .ilas_params_i(ilas_p), .ilas_valid_i(ilas_v),
    .ilas_lid_i(ilas_lid), .ilas_checksum_i(ilas_cks), .route_load_i(r_load),
    .tx_channel_select_i(r_tx), .route_i_src_i(r_isrc), .route_q_src_i(r_qsrc),
    .converters_enabled_i(conv_en), .pattern_error_tally_o(tally_o),
    .pattern_inverted_mask_o(inv_o), .ilas_mismatch_o(mm_o), .checksum_valid_o(csv_o),
    .received_lane0_params_o(rx_o), .local_link_config_o(lc_o),
    .converter_route_map_o(route_o), .dac_sample_o(dac_o));

  bb_pattern_model u_bb_pattern_model (
    .clk_sys_i(clk_sys), .order_i(order_sel), .run_i(run), .err_mask_i(err),
    .inv_mask_i(inv), .lane_data_o(lane_d), .lane_valid_o(lane_v));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic chk(input logic [66:0] g, input logic [66:0] e, input string what);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, g, e);
    end
  endtask : chk

  task automatic chk_range(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
    total_checks++;
    if ($isunknown(g) || g < lo || g > hi)
    begin
      num_errors++;
      $display("[FAIL] %0t tally %0h outside %0h..%0h", $time, g, lo, hi);
    end
  endtask : chk_range

  task automatic read_tally(input logic [1:0] lane);
    lsel = lane;
    tick(3);
    got = tally_o;
  endtask : read_tally

  task automatic clear();
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(2);
  endtask : clear

  task automatic arm(input logic [1:0] o);
    order_sel = 2'h0;
    tick(2);
    order_sel = o;
    tick(12);
    clear();
  endtask : arm

  function automatic logic [7:0] csum(input lane_params_t p, input logic [4:0] lid);
    return 8'(p.did + p.bid + lid + p.l + p.scr + p.f + p.k + p.m + p.n + p.cs + p.np
              + p.s + p.cf + p.hd);
  endfunction : csum

  task automatic ilas_send(input lane_params_t p, input logic [3:0] bad);
    logic [4:0] lid;
    ilas_p = p;
    for (int g = 0; g < 4; g++)
    begin
      lid = p.lid0 + 5'(g);
      ilas_lid[g*5+:5] = lid;
      ilas_cks[g*8+:8] = csum(p, lid) ^ {7'h00, bad[g]};
    end
    ilas_v = 1'b1;
    tick(1);
    ilas_v = 1'b0;
    tick(3);
  endtask : ilas_send

  task automatic route(input logic tx, input logic [1:0] i, input logic [1:0] q);
    r_load = 1'b1;
    r_tx = tx;
    r_isrc = i;
    r_qsrc = q;
    tick(1);
  endtask : route

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_clean();
    for (int o = 1; o < 4; o++)
    begin
      arm(2'(o));
      run = 1'b0;
      tick(3);
      run = 1'b1;
      tick(20);
      for (int g = 0; g < 4; g++)
      begin
        read_tally(2'(g));
        chk(got, 0, "clean lane tally");
      end
      chk(inv_o, 0, "no inverted lane");
    end
    $display("test clean done");
  endtask : t_clean

  task automatic t_error();
    arm(2'h1);
    err = 4'h4;
    tick(1);
    err = 4'h0;
    tick(8);
    for (int g = 0; g < 4; g++)
    begin
      read_tally(2'(g));
      if (g == 2) chk_range(got, 8'h01, 8'h03);
      else chk(got, 0, "quiet lane tally");
    end
    clear();
    for (int g = 0; g < 4; g++)
    begin
      read_tally(2'(g));
      chk(got, 0, "cleared tally");
    end
    $display("test error done");
  endtask : t_error

  task automatic t_saturate();
    arm(2'h3);
    err = 4'h2;
    tick(300);
    err = 4'h0;
    read_tally(2'h1);
    chk(got, TALLY_MAX, "saturated tally");
    read_tally(2'h0);
    chk(got, 0, "neighbour tally");
    clear();
    read_tally(2'h1);
    chk(got, 0, "tally after clear");
    $display("test saturate done");
  endtask : t_saturate

  task automatic t_invert();
    inv = 4'h8;
    arm(2'h2);
    tick(16);
    chk(inv_o, 4'h8, "inverted mask");
    read_tally(2'h3);
    chk(got, 0, "inverted lane tally");
    inv = 4'h0;
    $display("test invert done");
  endtask : t_invert

  task automatic t_sample();
    smode = 1'b1;
    arm(2'h1);
    err = 4'h2;
    tick(1);
    err = 4'h0;
    tick(8);
    read_tally(2'h3);
    chk_range(got, 8'h01, 8'h03);
    read_tally(2'h0);
    chk_range(got, 8'h01, 8'h03);
    smode = 1'b0;
    $display("test sample done");
  endtask : t_sample

  task automatic t_ilas();
    lane_params_t base;
    int pos [14] = '{59, 55, 50, 45, 44, 36, 31, 23, 18, 16, 11, 6, 1, 0};
    base = 67'h5A3C1123456789ABC;
    local_cfg = base;
    ilas_send(base, 4'h0);
    chk(mm_o, 0, "ilas match");
    chk(csv_o, 1, "checksum flag");
    chk(rx_o, base, "received params");
    chk(lc_o, base, "local params");
    for (int k = 0; k < 14; k++)
    begin
      ilas_send(base ^ (67'h1 << pos[k]), 4'h0);
      chk(mm_o, 32'h1 << k, "field mismatch");
    end
    for (int j = 0; j < 4; j++)
    begin
      ilas_send(base, 4'h1 << j);
      chk(mm_o, 32'h1 << (14 + j), "checksum mismatch");
      chk(csv_o, j != 0, "checksum flag");
    end
    $display("test ilas done");
  endtask : t_ilas

  task automatic t_route();
    chk(route_o, 8'hE4, "identity route");
    route(1'b0, 2'h3, 2'h2);
    route(1'b1, 2'h1, 2'h0);
    r_load = 1'b0;
    tick(3);
    chk(route_o, 8'h1B, "route map");
    chk(dac_o, 32'h1122_3344, "routed samples");
    conv_en = 3'h2;
    route(1'b0, 2'h3, 2'h2);
    route(1'b1, 2'h1, 2'h0);
    r_load = 1'b0;
    tick(3);
    chk(dac_o, 32'h1122_1111, "two converters");
    $display("test route done");
  endtask : t_route

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // clock, sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    {rst_b, clr, smode, ilas_v, r_load, r_tx, order_sel, lsel, r_isrc, r_qsrc} = '0;
    {err, inv, ilas_lid, ilas_cks, local_cfg, ilas_p} = '0;
    run = 1'b1;
    conv_en = 3'h4;
    dfo0 = 8'h11;
    dfo_hi = 24'h44_3322;
    num_errors = 0;
    total_checks = 0;
    tick(16);
    rst_b = 1'b1;
    tick(3);
    t_route();
    t_clean();
    t_error();
    t_saturate();
    t_invert();
    t_sample();
    t_ilas();
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule : deframer_prbs_ilas_check_tb_top
